// ---- pfcc_pkg.sv ----
package pfcc_pkg;
  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_CFG  = 12'h400;
  localparam logic [11:0] IDX_A0   = 12'h418;
  localparam logic [11:0] IDX_A1   = 12'h41a;
  localparam logic [11:0] IDX_B0   = 12'h440;
  localparam logic [11:0] IDX_B1   = 12'h442;
  localparam logic [11:0] IDX_LINK = 12'h480;
  localparam logic [11:0] IDX_STAT = 12'h481;
  // filter_config fields
  localparam int          SHARE_BIT = 6;
  localparam int          MERGE_BIT = 5;
  localparam int          SCW_LSB   = 2;
  localparam int          SCW_W     = 3;
  localparam int          MODE_LSB  = 0;
  localparam int          MODE_W    = 2;
  localparam logic [1:0]  MODE_OFF  = 2'h0;
  localparam logic [1:0]  MODE_ON   = 2'h2;
  localparam logic [2:0]  SCW_MAX   = 3'h6;
  localparam logic [7:0]  CFG_RST   = 8'h00;
  localparam logic [11:0] COEF_RST  = 12'h000;
  localparam int          COEF_W    = 12;
  localparam int          SAMP_W    = 12;
  // side lsb is 2^(scw-16); center lsb fixed at 2^-11
  localparam int          FRAC_W    = 16;
  localparam int          CTR_SHIFT = 5;
  localparam int          FIFO_D    = 8;
  localparam logic [1:0]  HTRANS_NONSEQ_BIT = 2'h2;
endpackage

// ---- pfcc_top.sv ----
// Chosen here: register access over AHB-Lite.
`timescale 1ns/100ps

module pfcc_fifo
#(
  parameter int W = 24,
  parameter int D = 8
)
(
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   in_valid,
  output logic                        in_ready,
  input  wire logic [W-1:0]           in_data,
  output logic                        out_valid,
  input  wire logic                   out_ready,
  output logic [W-1:0]                out_data,
  output logic [$clog2(D+1)-1:0]      count
);
  localparam int PW = $clog2(D);
  localparam logic [$clog2(D+1)-1:0] FULL = ($clog2(D+1))'(D);
  localparam logic [PW-1:0] LAST = PW'(D - 1);
  logic [W-1:0]  mem [D];
  logic [PW-1:0] wptr;
  logic [PW-1:0] rptr;
  logic          push;
  logic          pop;
  assign in_ready  = count != FULL;
  assign out_valid = count != '0;
  assign out_data  = mem[rptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge hclk)
  begin
    if (push)
      mem[wptr] <= in_data;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wptr <= (wptr == LAST) ? '0 : wptr + 1'b1;
      if (pop)
        rptr <= (rptr == LAST) ? '0 : rptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
endmodule

// Overview of operation
// - with share set, channel B filters with the channel A coefficients.
// - with share and merge both clear, channel B filters with its own coefficients.
// - with merge set, both filters act as one over a single stream.
// - the side weight scales all but the center tap by 2^(min(field,6)-16).
// - larger side weight trades precision for range; 0 gives 2^-16.
// - mode 0 disables the filter, 2 enables it, 1 and 3 are reserved.
// - each coefficient is signed 12-bit in bits 11:0, 15:12 reserved.
// - coef_a_tap0 is the first tap of channel A or of the merged filter.
// - coef_a_tap1 is the second tap of channel A or the merged filter.
module pfcc_top
#(
  parameter int DEPTH = pfcc_pkg::FIFO_D
)
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        samp_valid,
  output logic             samp_ready,
  input  wire logic [11:0] samp_a,
  input  wire logic [11:0] samp_b,
  output logic             out_valid,
  input  wire logic        out_ready,
  output logic [11:0]      out_a,
  output logic [11:0]      out_b,
  output logic             serial_link_enable
);
  localparam int CW = $clog2(DEPTH + 1);
  logic [7:0]                filter_config;
  logic signed [11:0]        coef_a_tap0;
  logic signed [11:0]        coef_a_tap1;
  logic signed [11:0]        coef_b_tap0;
  logic signed [11:0]        coef_b_tap1;
  logic                      wr_pend;
  logic                      rd_phase;
  logic                      dp_ok;
  logic [11:0]               dp_idx;
  logic                      acc;
  logic                      filt_on;
  logic                      share_a_coefs_with_b;
  logic                      merge_channel_filters;
  logic [2:0]                side_coef_weight;
  logic [1:0]                filter_mode_select;
  logic signed [11:0]        eff_b0;
  logic signed [11:0]        eff_b1;
  logic signed [11:0]        hist_a;
  logic signed [11:0]        hist_b;
  logic signed [11:0]        old_a;
  logic signed [11:0]        old_b;
  logic [11:0]               y_a;
  logic [11:0]               y_b;
  logic [23:0]               wr_data;
  logic [23:0]               rd_data;
  logic                      fifo_valid;
  logic [CW-1:0]             fifo_count;
  logic                      take;

  assign acc       = hsel && htrans[1] && hready;
  // reads take one wait state so hrdata always comes from a flop
  assign hreadyout = !rd_phase;
  assign hresp     = 1'b0;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend  <= 1'b0;
      rd_phase <= 1'b0;
      dp_ok    <= 1'b0;
      dp_idx   <= '0;
    end
    else
    begin
      wr_pend  <= acc && hwrite;
      rd_phase <= acc && !hwrite;
      if (acc)
      begin
        dp_idx <= haddr[13:2];
        dp_ok  <= (haddr[31:14] == '0) && (haddr[1:0] == 2'h0);
      end
    end
  end
  function automatic logic [31:0] rd_mux(input logic [11:0] idx);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (idx)
      pfcc_pkg::IDX_CFG:  r[7:0]  = filter_config;
      pfcc_pkg::IDX_A0:   r[11:0] = coef_a_tap0;
      pfcc_pkg::IDX_A1:   r[11:0] = coef_a_tap1;
      pfcc_pkg::IDX_B0:   r[11:0] = coef_b_tap0;
      pfcc_pkg::IDX_B1:   r[11:0] = coef_b_tap1;
      pfcc_pkg::IDX_LINK: r[0]    = serial_link_enable;
      pfcc_pkg::IDX_STAT: r[7:0]  = {3'h0, 4'(fifo_count), filt_on};
      default:            r       = 32'h0000_0000;
    endcase
    return r;
  endfunction

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (rd_phase)
      hrdata <= dp_ok ? rd_mux(dp_idx) : 32'h0000_0000;
  end
  // coefficient bits 15:12 are not stored and read back as zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      filter_config      <= pfcc_pkg::CFG_RST;
      coef_a_tap0        <= pfcc_pkg::COEF_RST;
      coef_a_tap1        <= pfcc_pkg::COEF_RST;
      coef_b_tap0        <= pfcc_pkg::COEF_RST;
      coef_b_tap1        <= pfcc_pkg::COEF_RST;
      serial_link_enable <= 1'b0;
    end
    else if (wr_pend && dp_ok)
    begin
      unique case (dp_idx)
        pfcc_pkg::IDX_CFG:  filter_config      <= hwdata[7:0];
        pfcc_pkg::IDX_A0:   coef_a_tap0        <= hwdata[11:0];
        pfcc_pkg::IDX_A1:   coef_a_tap1        <= hwdata[11:0];
        pfcc_pkg::IDX_B0:   coef_b_tap0        <= hwdata[11:0];
        pfcc_pkg::IDX_B1:   coef_b_tap1        <= hwdata[11:0];
        pfcc_pkg::IDX_LINK: serial_link_enable <= hwdata[0];
        default:            ;
      endcase
    end
  end

  assign share_a_coefs_with_b  = filter_config[pfcc_pkg::SHARE_BIT];
  assign merge_channel_filters = filter_config[pfcc_pkg::MERGE_BIT];
  assign filter_mode_select    =
    filter_config[pfcc_pkg::MODE_LSB +: pfcc_pkg::MODE_W];
  // reserved modes leave the filter off
  assign filt_on = filter_mode_select == pfcc_pkg::MODE_ON;
  // out-of-range weights clamp to the largest legal one
  always_comb
  begin
    side_coef_weight = filter_config[pfcc_pkg::SCW_LSB +: pfcc_pkg::SCW_W];
    if (side_coef_weight > pfcc_pkg::SCW_MAX)
      side_coef_weight = pfcc_pkg::SCW_MAX;
  end
  // merged filter runs on A coefficients for both phases
  always_comb
  begin
    if (share_a_coefs_with_b || merge_channel_filters)
    begin
      eff_b0 = coef_a_tap0;
      eff_b1 = coef_a_tap1;
    end
    else
    begin
      eff_b0 = coef_b_tap0;
      eff_b1 = coef_b_tap1;
    end
  end
  // merged stream order is a then b, so b's previous sample is a
  always_comb
  begin
    if (merge_channel_filters)
    begin
      old_a = hist_b;
      old_b = samp_a;
    end
    else
    begin
      old_a = hist_a;
      old_b = hist_b;
    end
  end
  function automatic logic [11:0] fir2(
    input logic signed [11:0] x0,
    input logic signed [11:0] x1,
    input logic signed [11:0] c0,
    input logic signed [11:0] c1,
    input logic [2:0]         scw
  );
    logic signed [31:0] e0;
    logic signed [31:0] e1;
    logic signed [31:0] s;
    e0 = 32'(x0) * 32'(c0);
    e1 = 32'(x1) * 32'(c1);
    // tap0 is the center tap; tap1 is a side tap
    s = (e0 <<< pfcc_pkg::CTR_SHIFT) + (e1 <<< scw);
    s = s >>> pfcc_pkg::FRAC_W;
    if (s > 32'sd2047)
      return 12'h7ff;
    else if (s < -32'sd2048)
      return 12'h800;
    return s[11:0];
  endfunction

  assign y_a = fir2(samp_a, old_a, coef_a_tap0, coef_a_tap1,
                    side_coef_weight);
  assign y_b = fir2(samp_b, old_b, eff_b0, eff_b1, side_coef_weight);
  assign wr_data = filt_on ? {y_b, y_a}
                           : {samp_b, samp_a};
  assign take    = samp_valid && samp_ready;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hist_a <= '0;
      hist_b <= '0;
    end
    else if (take)
    begin
      hist_a <= samp_a;
      hist_b <= samp_b;
    end
  end

  // the link drains only while enabled, so a stopped link fills the fifo
  pfcc_fifo #(.W(2 * pfcc_pkg::SAMP_W), .D(DEPTH)) u_fifo
  (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .in_valid  (samp_valid),
    .in_ready  (samp_ready),
    .in_data   (wr_data),
    .out_valid (fifo_valid),
    .out_ready (out_ready && serial_link_enable),
    .out_data  (rd_data),
    .count     (fifo_count)
  );
  assign out_valid = fifo_valid && serial_link_enable;
  assign out_a     = rd_data[11:0];
  assign out_b     = rd_data[23:12];

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_share_b_coefs: assert property (
    share_a_coefs_with_b |-> eff_b0 == coef_a_tap0 && eff_b1 == coef_a_tap1)
    else $error("b filter not using a coefficients while shared");
  a_own_b_coefs: assert property (
    !share_a_coefs_with_b && !merge_channel_filters
      |-> eff_b0 == coef_b_tap0 && eff_b1 == coef_b_tap1)
    else $error("b filter not using its own coefficients");
  a_merge_stream: assert property (
    merge_channel_filters && take |=> old_a == $past(samp_b))
    else $error("merged filter lost stream order");
  a_side_weight_cap: assert property (
    side_coef_weight <= pfcc_pkg::SCW_MAX)
    else $error("side weight beyond legal range");
  a_mode_enable: assert property (
    wr_pend && dp_ok && dp_idx == pfcc_pkg::IDX_CFG
      |=> filt_on == ($past(hwdata[1:0]) == pfcc_pkg::MODE_ON))
    else $error("mode write did not steer the filter");
  a_coef_readback: assert property (
    rd_phase && dp_ok && dp_idx == pfcc_pkg::IDX_A0
      |=> hrdata == {20'h0_0000, $past(coef_a_tap0)})
    else $error("tap0 readback wrong");
  a_bypass_data: assert property (
    take && !filt_on && u_fifo.count == '0
      |=> out_a == $past(samp_a) && out_b == $past(samp_b))
    else $error("disabled filter altered samples");
  a_read_wait: assert property (
    acc && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_link_gate: assert property (
    !serial_link_enable |-> !out_valid)
    else $error("data left while link disabled");
endmodule

// ---- pfcc_tb.sv ----
`timescale 1ns/100ps
`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      error_cnt++; \
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end

module testbench;
  typedef struct packed {
    logic [7:0]  cfg;
    logic [11:0] a0, a1, b0, b1, xa0, xb0, xa1, xb1;
  } pfcc_row_s;
  localparam logic [31:0] CFG  = 32'(pfcc_pkg::IDX_CFG) << 2;
  localparam logic [31:0] A0   = 32'(pfcc_pkg::IDX_A0) << 2;
  localparam logic [31:0] A1   = 32'(pfcc_pkg::IDX_A1) << 2;
  localparam logic [31:0] B0   = 32'(pfcc_pkg::IDX_B0) << 2;
  localparam logic [31:0] B1   = 32'(pfcc_pkg::IDX_B1) << 2;
  localparam logic [31:0] LINK = 32'(pfcc_pkg::IDX_LINK) << 2;
  localparam logic [31:0] STAT = 32'(pfcc_pkg::IDX_STAT) << 2;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        samp_valid, samp_ready, out_valid, out_ready, link_on;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [11:0] samp_a, samp_b, out_a, out_b, ha, hb;
  logic [23:0] expq [$];
  int          error_cnt, samples_checked;
  pfcc_row_s   hr;
  // off, dual, share, merge, scw 0, saturate, reserved modes 1 and 3
  pfcc_row_s   rows [8] = '{
    '{8'h00, 12'h400, 12'h400, 12'h200, 12'hc00,
      12'h100, 12'h0f0, 12'hffc, 12'h020},
    '{8'h1a, 12'h400, 12'h400, 12'h200, 12'hc00,
      12'h040, 12'h080, 12'h0c0, 12'hf80},
    '{8'h5a, 12'h400, 12'h400, 12'h200, 12'hc00,
      12'h100, 12'h200, 12'hf00, 12'h010},
    '{8'h3a, 12'h400, 12'h400, 12'h200, 12'hc00,
      12'h040, 12'h080, 12'h100, 12'hf00},
    '{8'h02, 12'h000, 12'h400, 12'h000, 12'h400,
      12'h7c0, 12'h840, 12'h400, 12'hc00},
    '{8'h1a, 12'h400, 12'h400, 12'h400, 12'h400,
      12'h7fe, 12'h800, 12'h7fe, 12'h800},
    '{8'h19, 12'h400, 12'h400, 12'h400, 12'h400,
      12'h123, 12'h456, 12'h789, 12'habc},
    '{8'h1b, 12'h400, 12'h400, 12'h400, 12'h400,
      12'h321, 12'h654, 12'h987, 12'hcba}
  };

  pfcc_top #(.DEPTH(8)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .samp_valid(samp_valid), .samp_ready(samp_ready),
    .samp_a(samp_a), .samp_b(samp_b), .out_valid(out_valid),
    .out_ready(out_ready), .out_a(out_a), .out_b(out_b),
    .serial_link_enable(link_on)
  );

  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  function automatic logic [11:0] fir(input logic [11:0] x0, x1, c0, c1,
                                      input logic [7:0] cfg);
    longint s;
    logic [2:0] w;
    if (cfg[1:0] != pfcc_pkg::MODE_ON) return x0;
    // weights above the legal range act as the largest legal one
    w = (cfg[4:2] > pfcc_pkg::SCW_MAX) ? pfcc_pkg::SCW_MAX : cfg[4:2];
    s = (longint'($signed(x0)) * longint'($signed(c0))
         <<< pfcc_pkg::CTR_SHIFT)
      + (longint'($signed(x1)) * longint'($signed(c1)) <<< w);
    s = s >>> 16;
    if (s > 2047) s = 2047;
    if (s < -2048) s = -2048;
    return s[11:0];
  endfunction

  task automatic close_out;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ready is looked at mid-cycle so the edge's own updates never race us
  task automatic rdy(output logic [31:0] r);
    @(negedge hclk);
    while (hreadyout !== 1'b1) @(negedge hclk);
    r = hrdata;
    @(posedge hclk);
  endtask

  task automatic bus(input logic w, input logic [31:0] a, d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= pfcc_pkg::HTRANS_NONSEQ_BIT;
    rdy(r);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy(r);
  endtask

  task automatic wr(input logic [31:0] a, d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rdc(input logic [31:0] a, e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0000_0000, r);
    `CHK(r, e)
    `CHK(hresp, 1'b0)
  endtask

  task automatic push(input logic [11:0] xa, xb, input pfcc_row_s r);
    logic [11:0] ea, eb;
    ea = fir(xa, r.cfg[5] ? hb : ha, r.a0, r.a1, r.cfg);
    if (r.cfg[5]) eb = fir(xb, xa, r.a0, r.a1, r.cfg);
    else if (r.cfg[6]) eb = fir(xb, hb, r.a0, r.a1, r.cfg);
    else eb = fir(xb, hb, r.b0, r.b1, r.cfg);
    expq.push_back({ea, eb});
    ha = xa;
    hb = xb;
    samp_valid <= 1'b1;
    samp_a <= xa;
    samp_b <= xb;
    @(negedge hclk);
    while (samp_ready !== 1'b1) @(negedge hclk);
    @(posedge hclk);
  endtask

  task automatic pop;
    logic [23:0] e;
    out_ready <= 1'b1;
    @(negedge hclk);
    while (out_valid !== 1'b1) @(negedge hclk);
    e = expq.pop_front();
    `CHK({out_a, out_b}, e)
    @(posedge hclk);
  endtask

  initial
  begin
    repeat (30000) @(posedge hclk);
    error_cnt++;
    close_out();
  end

  initial
  begin
    {hresetn, hsel, hwrite, samp_valid, out_ready} = 5'h00;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    {samp_a, samp_b, ha, hb} = 48'h0000_0000_0000;
    error_cnt = 0;
    samples_checked = 0;
    repeat (8) @(posedge hclk);
    `CHK({hreadyout, out_valid, samp_ready, link_on}, 4'ha)
    hresetn <= 1'b1;
    rdc(CFG, 32'h0000_0000);
    rdc(A0, 32'h0000_0000);
    rdc(A1, 32'h0000_0000);
    wr(CFG, 32'hffff_ffff);
    rdc(CFG, 32'h0000_00ff);
    wr(A1, 32'hffff_ffff);
    rdc(A1, 32'h0000_0fff);
    rdc(CFG + 32'h0000_0004, 32'h0000_0000);
    // configuration only moves while the link is off
    foreach (rows[i])
    begin
      wr(CFG, 32'(rows[i].cfg));
      rdc(CFG, 32'(rows[i].cfg));
      wr(A0, 32'(rows[i].a0));
      wr(A1, 32'(rows[i].a1));
      wr(B0, 32'(rows[i].b0));
      wr(B1, 32'(rows[i].b1));
      push(rows[i].xa0, rows[i].xb0, rows[i]);
      push(rows[i].xa1, rows[i].xb1, rows[i]);
      samp_valid <= 1'b0;
      rdc(STAT, {27'h0, 4'h2, rows[i].cfg[1:0] == 2'h2});
      wr(LINK, 32'h0000_0001);
      pop();
      pop();
      out_ready <= 1'b0;
      wr(LINK, 32'h0000_0000);
    end
    wr(CFG, 32'h0000_0000);
    for (int i = 0; i < 8; i++) push(12'(i * 100), 12'(-i), rows[0]);
    repeat (3)
    begin
      @(negedge hclk);
      `CHK({samp_ready, out_valid}, 2'h0)
    end
    @(posedge hclk);
    samp_valid <= 1'b0;
    rdc(STAT, 32'h0000_0010);
    wr(LINK, 32'h0000_0001);
    repeat (8)
    begin
      pop();
      out_ready <= 1'b0;
      @(posedge hclk);
    end
    @(negedge hclk);
    `CHK({out_valid, samp_ready, link_on}, 3'h3)
    @(posedge hclk);
    wr(LINK, 32'h0000_0000);
    hr = rows[5];
    hr.cfg = 8'h1e;
    wr(CFG, 32'(hr.cfg));
    push(12'h010, 12'h020, hr);
    samp_valid <= 1'b0;
    wr(LINK, 32'h0000_0001);
    pop();
    out_ready <= 1'b0;
    wr(LINK, 32'h0000_0000);
    wr(CFG, 32'h0000_005a);
    wr(LINK, 32'h0000_0001);
    hresetn <= 1'b0;
    @(negedge hclk);
    `CHK({hreadyout, link_on}, 2'h2)
    @(posedge hclk);
    hresetn <= 1'b1;
    rdc(CFG, 32'h0000_0000);
    close_out();
  end
endmodule
